// File: design/ocs_clk_divider.sv
// Tick-driven divider producing a square wave of DIV ticks per period.
`timescale 1ns/1ps
`default_nettype none
module ocs_clk_divider #(
	parameter int DIV = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	output logic div_out
);
	localparam int HALF = DIV / 2;
	localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

	logic [CW-1:0] count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			div_out <= 1'b0;
		end else if (tick) begin
			if (count == CW'(HALF - 1)) begin
				count <= '0;
				div_out <= ~div_out;
			end else begin
				count <= count + CW'(1);
			end
		end
	end

endmodule : ocs_clk_divider
`default_nettype wire

// File: design/ocs_pkg.sv
// Types shared by the oscillator select block.
package ocs_pkg;

	typedef enum logic [3:0] {
		OCS_LP = 4'h0,
		OCS_XT = 4'h1,
		OCS_HS = 4'h2,
		OCS_RC = 4'h3,
		OCS_EXT_CLOCK = 4'h4,
		OCS_EXT_CLOCK_IO = 4'h5,
		OCS_HIGH_SPEED_X4 = 4'h6,
		OCS_RC_WITH_IO = 4'h7,
		OCS_INTERNAL_FULL_IO = 4'h8,
		OCS_INTERNAL_CLKOUT = 4'h9
	} ocs_mode_e;

	typedef enum logic [3:0] {
		OCS_SRC_XTAL = 4'h0,
		OCS_SRC_XTAL_X4 = 4'h1,
		OCS_SRC_EXT_PIN = 4'h2,
		OCS_SRC_EXT_RC = 4'h3,
		OCS_SRC_FAST = 4'h4,
		OCS_SRC_FAST_X4 = 4'h5,
		OCS_SRC_POSTSCALED = 4'h6,
		OCS_SRC_SLOW_RC = 4'h7,
		OCS_SRC_FAST_DIV = 4'h8
	} ocs_src_e;

	typedef struct packed {
		logic o;
		logic oe;
	} ocs_pin_s;

endpackage : ocs_pkg

// File: design/ocs_regs.svh
// Register offsets, field positions, reset values and timing counts of the oscillator select block.
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

`define OCS_ADDR_W 12
`define OCS_OFF_TUNE 12'h000
`define OCS_OFF_CTRL 12'h004
`define OCS_OFF_FEAT 12'h008
`define OCS_OFF_STAT 12'h00c

`define OCS_TUNE_LFSRC_BIT 7
`define OCS_TUNE_MULT_BIT 6
`define OCS_TUNE_TRIM_LSB 0
`define OCS_TUNE_TRIM_W 5
`define OCS_TUNE_RESET 8'h00

`define OCS_CTRL_FREQ_LSB 4
`define OCS_CTRL_RESET 3'h0

`define OCS_FEAT_PWRT_BIT 0
`define OCS_FEAT_FSCM_BIT 1
`define OCS_FEAT_WDT_BIT 2
`define OCS_FEAT_TWOSPD_BIT 3
`define OCS_FEAT_RESET 4'h0

`define OCS_MODE_RESET 4'h4
`define OCS_FREQ_8M 3'h7
`define OCS_FREQ_4M 3'h6
`define OCS_FREQ_31K 3'h0
`define OCS_FOSC_DIV 4
`define OCS_LF_DIV 256

`define OCS_PCLK_MHZ 200
`define OCS_FAST_SETTLE_US 1000
`define OCS_TUNE_SETTLE_CYC (`OCS_FAST_SETTLE_US * `OCS_PCLK_MHZ)

`endif

// File: design/ocs_top.sv
// Oscillator mode decode, pin assignment, multiplier routing and internal clock selection.
//
// Operation
// - Ten oscillator modes are chosen from a four-bit configuration field.
// - External clock mode takes the input pin and drives Fosc/4 out.
// - External clock modes need no oscillator start-up delay.
// - External clock with I/O turns the output pin into port A bit 6.
// - RC mode drives Fosc/4 on the oscillator output pin.
// - RC with I/O is RC mode with the output pin as port A bit 6.
// - High-speed x4 mode multiplies a crystal up to 10 MHz by four.
// - Crystal multiplier runs only for code 0110; software enable ignored there.
// - Software may enable x4 on the fast internal oscillator, up to 32 MHz.
// - Internal multiplier needs mode 1001/1000 and frequency code 111/110.
// - Outside the internal modes the internal multiplier enable bit is forced to zero.
// - Fast internal oscillator gives 8 MHz direct or postscaled down to 31 kHz.
// - Fast oscillator enabled for selections of 125 kHz to 8 MHz, and at 31 kHz when the source bit picks it in an internal mode.
// - Slow RC runs when selected or any timer or monitor feature needs it.
// - Frequency select field picks fast direct, slow RC or postscaled fast.
// - Internal clock-out mode drives Fosc/4 out and input pin as bit 7.
// - Internal full I/O mode makes both oscillator pins port A bits.
// - Tuning writes settle silently; execution continues without any indication.
// - Low-frequency source bit picks the internal source for 31 kHz.
// - Source bit one divides fast oscillator by 256; zero uses slow RC.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ocs_regs.svh"
module ocs_top #(
	parameter int TUNE_SETTLE_CYC = `OCS_TUNE_SETTLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`OCS_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] osc_mode_cfg,
	input wire logic fast_osc_tick,
	input wire logic osc_in_pin_i,
	input wire logic osc_out_pin_i,
	output ocs_pkg::ocs_pin_s osc_in_pin_drv,
	output ocs_pkg::ocs_pin_s osc_out_pin_drv,
	input wire ocs_pkg::ocs_pin_s port_a_bit6_drv,
	input wire ocs_pkg::ocs_pin_s port_a_bit7_drv,
	output logic port_a_bit6_in,
	output logic port_a_bit7_in,
	output ocs_pkg::ocs_src_e clk_src_sel,
	output logic [2:0] postscale_sel,
	output logic xtal_mult_en,
	output logic fast_internal_osc_mult_run,
	output logic fast_osc_en,
	output logic slow_rc_en,
	output logic startup_delay_en,
	output logic [`OCS_TUNE_TRIM_W-1:0] tune_trim,
	output logic tune_settling,
	output logic lf_clk
);
	localparam int SW = $clog2(TUNE_SETTLE_CYC + 1);

	function automatic logic is_internal(input ocs_pkg::ocs_mode_e m);
		return (m == ocs_pkg::OCS_INTERNAL_CLKOUT) || (m == ocs_pkg::OCS_INTERNAL_FULL_IO);
	endfunction : is_internal

	function automatic logic out_is_div4(input ocs_pkg::ocs_mode_e m);
		return (m == ocs_pkg::OCS_EXT_CLOCK) || (m == ocs_pkg::OCS_RC)
			|| (m == ocs_pkg::OCS_INTERNAL_CLKOUT);
	endfunction : out_is_div4

	function automatic logic out_is_io(input ocs_pkg::ocs_mode_e m);
		return (m == ocs_pkg::OCS_EXT_CLOCK_IO) || (m == ocs_pkg::OCS_RC_WITH_IO)
			|| (m == ocs_pkg::OCS_INTERNAL_FULL_IO);
	endfunction : out_is_io

	ocs_pkg::ocs_mode_e mode;
	logic mode_loaded;
	logic lf_src_sel;
	logic mult_sw_en;
	logic [2:0] freq_sel;
	logic [3:0] feat_en;
	logic [SW-1:0] settle_count;
	logic div4_level;
	logic div256_level;
	logic acc_phase;
	logic wr_hit;
	logic mapped;
	logic [31:0] rd_mux;
	logic mult_ok;
	ocs_pkg::ocs_src_e next_src;

	ocs_clk_divider #(.DIV(`OCS_FOSC_DIV)) u_div4 (
		.pclk(pclk),
		.presetn(presetn),
		.tick(1'b1),
		.div_out(div4_level)
	);

	ocs_clk_divider #(.DIV(`OCS_LF_DIV)) u_div256 (
		.pclk(pclk),
		.presetn(presetn),
		.tick(fast_osc_tick),
		.div_out(div256_level)
	);

	// The mode field is a strap: it is caught by a clock edge after release, never by the reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= ocs_pkg::ocs_mode_e'(`OCS_MODE_RESET);
			mode_loaded <= 1'b0;
		end else if (!mode_loaded) begin
			mode <= ocs_pkg::ocs_mode_e'(osc_mode_cfg);
			mode_loaded <= 1'b1;
		end
	end

	assign acc_phase = psel && penable && pready;
	assign wr_hit = acc_phase && pwrite;
	assign mapped = (paddr == `OCS_OFF_TUNE) || (paddr == `OCS_OFF_CTRL)
		|| (paddr == `OCS_OFF_FEAT) || (paddr == `OCS_OFF_STAT);
	assign mult_ok = is_internal(mode) && mode_loaded;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`OCS_OFF_TUNE: begin
				rd_mux[`OCS_TUNE_LFSRC_BIT] = lf_src_sel;
				rd_mux[`OCS_TUNE_MULT_BIT] = mult_sw_en;
				rd_mux[`OCS_TUNE_TRIM_LSB +: `OCS_TUNE_TRIM_W] = tune_trim;
			end
			`OCS_OFF_CTRL: rd_mux[`OCS_CTRL_FREQ_LSB +: 3] = freq_sel;
			`OCS_OFF_FEAT: rd_mux[3:0] = feat_en;
			`OCS_OFF_STAT: rd_mux[9:0] = {startup_delay_en, slow_rc_en, fast_osc_en,
				fast_internal_osc_mult_run, xtal_mult_en, mode_loaded, mode};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait state: pready rises the cycle after the access phase opens and read data is
	// registered with it, so the bus output never depends combinationally on the address.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= !mapped;
		end else begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// Tuning register; the multiplier bit only holds a one in the internal oscillator modes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_src_sel <= 1'(`OCS_TUNE_RESET >> `OCS_TUNE_LFSRC_BIT);
			mult_sw_en <= 1'b0;
			tune_trim <= '0;
		end else begin
			if (!mult_ok) begin
				mult_sw_en <= 1'b0;
			end
			if (wr_hit && paddr == `OCS_OFF_TUNE) begin
				lf_src_sel <= pwdata[`OCS_TUNE_LFSRC_BIT];
				mult_sw_en <= pwdata[`OCS_TUNE_MULT_BIT] && mult_ok;
				tune_trim <= pwdata[`OCS_TUNE_TRIM_LSB +: `OCS_TUNE_TRIM_W];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_sel <= `OCS_CTRL_RESET;
			feat_en <= `OCS_FEAT_RESET;
		end else if (wr_hit) begin
			if (paddr == `OCS_OFF_CTRL) begin
				freq_sel <= pwdata[`OCS_CTRL_FREQ_LSB +: 3];
			end
			if (paddr == `OCS_OFF_FEAT) begin
				feat_en <= pwdata[3:0];
			end
		end
	end

	// Retuning is not visible to software; the settle window only masks the clock monitor,
	// which would otherwise trip on the intended frequency shift.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_count <= '0;
			tune_settling <= 1'b0;
		end else if (wr_hit && paddr == `OCS_OFF_TUNE) begin
			settle_count <= SW'(TUNE_SETTLE_CYC);
			tune_settling <= 1'b1;
		end else if (settle_count != '0) begin
			settle_count <= settle_count - SW'(1);
			tune_settling <= (settle_count != SW'(1));
		end
	end

	always_comb begin
		case (mode)
			ocs_pkg::OCS_LP, ocs_pkg::OCS_XT, ocs_pkg::OCS_HS: next_src = ocs_pkg::OCS_SRC_XTAL;
			ocs_pkg::OCS_HIGH_SPEED_X4: next_src = ocs_pkg::OCS_SRC_XTAL_X4;
			ocs_pkg::OCS_EXT_CLOCK, ocs_pkg::OCS_EXT_CLOCK_IO: next_src = ocs_pkg::OCS_SRC_EXT_PIN;
			ocs_pkg::OCS_RC, ocs_pkg::OCS_RC_WITH_IO: next_src = ocs_pkg::OCS_SRC_EXT_RC;
			ocs_pkg::OCS_INTERNAL_CLKOUT, ocs_pkg::OCS_INTERNAL_FULL_IO: begin
				if (freq_sel == `OCS_FREQ_31K) begin
					next_src = lf_src_sel ? ocs_pkg::OCS_SRC_FAST_DIV : ocs_pkg::OCS_SRC_SLOW_RC;
				end else if (mult_sw_en && (freq_sel == `OCS_FREQ_8M || freq_sel == `OCS_FREQ_4M)) begin
					next_src = ocs_pkg::OCS_SRC_FAST_X4;
				end else if (freq_sel == `OCS_FREQ_8M) begin
					next_src = ocs_pkg::OCS_SRC_FAST;
				end else begin
					next_src = ocs_pkg::OCS_SRC_POSTSCALED;
				end
			end
			default: next_src = ocs_pkg::OCS_SRC_EXT_RC;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_src_sel <= ocs_pkg::OCS_SRC_EXT_PIN;
			postscale_sel <= `OCS_CTRL_RESET;
			xtal_mult_en <= 1'b0;
			fast_internal_osc_mult_run <= 1'b0;
			fast_osc_en <= 1'b0;
			slow_rc_en <= 1'b0;
			startup_delay_en <= 1'b0;
			lf_clk <= 1'b0;
		end else begin
			clk_src_sel <= next_src;
			postscale_sel <= freq_sel;
			xtal_mult_en <= mode_loaded && mode == ocs_pkg::OCS_HIGH_SPEED_X4;
			fast_internal_osc_mult_run <= mult_ok && mult_sw_en
				&& (freq_sel == `OCS_FREQ_8M || freq_sel == `OCS_FREQ_4M);
			fast_osc_en <= (freq_sel != `OCS_FREQ_31K)
				|| (lf_src_sel && is_internal(mode));
			slow_rc_en <= (next_src == ocs_pkg::OCS_SRC_SLOW_RC) || (feat_en != 4'h0);
			startup_delay_en <= mode_loaded && mode != ocs_pkg::OCS_EXT_CLOCK
				&& mode != ocs_pkg::OCS_EXT_CLOCK_IO;
			lf_clk <= div256_level;
		end
	end

	// Pin routing. In the crystal modes both pins belong to the analog amplifier, so the
	// digital drivers stay off; an external clock on the input pin then simply passes through.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_out_pin_drv <= '0;
			osc_in_pin_drv <= '0;
			port_a_bit6_in <= 1'b0;
			port_a_bit7_in <= 1'b0;
		end else begin
			if (mode_loaded && out_is_div4(mode)) begin
				osc_out_pin_drv <= '{o: div4_level, oe: 1'b1};
			end else if (mode_loaded && out_is_io(mode)) begin
				osc_out_pin_drv <= port_a_bit6_drv;
			end else begin
				osc_out_pin_drv <= '0;
			end
			port_a_bit6_in <= mode_loaded && out_is_io(mode) && osc_out_pin_i;
			if (mode_loaded && is_internal(mode)) begin
				osc_in_pin_drv <= port_a_bit7_drv;
			end else begin
				osc_in_pin_drv <= '0;
			end
			port_a_bit7_in <= mode_loaded && is_internal(mode) && osc_in_pin_i;
		end
	end

	AST_MODE_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		$past(mode_loaded) |-> $stable(mode))
		else $error("Oscillator mode changed after it was sampled.");

	AST_XTAL_MULT: assert property (@(posedge pclk) disable iff (!presetn)
		##1 xtal_mult_en == $past(mode_loaded && mode == ocs_pkg::OCS_HIGH_SPEED_X4))
		else $error("Crystal multiplier enable does not follow the x4 mode.");

	AST_MULT_FORCED: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_loaded && !is_internal(mode)) |=> !mult_sw_en && !fast_internal_osc_mult_run)
		else $error("Internal multiplier enable set outside the internal modes.");

	AST_MULT_FREQ: assert property (@(posedge pclk) disable iff (!presetn)
		fast_internal_osc_mult_run |-> $past(freq_sel == `OCS_FREQ_8M || freq_sel == `OCS_FREQ_4M))
		else $error("Internal multiplier running at a frequency other than 4 or 8 MHz.");

	AST_DIV4_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_loaded && out_is_div4(mode) && $past(mode_loaded, 4))
		|-> osc_out_pin_drv.oe && osc_out_pin_drv.o == !$past(osc_out_pin_drv.o, 2))
		else $error("Oscillator output pin is not a divide-by-4 clock.");

	AST_IO_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_loaded && out_is_io(mode)) |=> osc_out_pin_drv == $past(port_a_bit6_drv))
		else $error("Oscillator output pin not handed to port A bit 6.");

	AST_NO_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_loaded && (mode == ocs_pkg::OCS_EXT_CLOCK || mode == ocs_pkg::OCS_EXT_CLOCK_IO))
		|=> !startup_delay_en)
		else $error("Start-up delay requested in an external clock mode.");

	AST_FAST_EN: assert property (@(posedge pclk) disable iff (!presetn)
		(freq_sel != `OCS_FREQ_31K) |=> fast_osc_en)
		else $error("Fast oscillator off while 125 kHz to 8 MHz is selected.");

	AST_SLOW_EN: assert property (@(posedge pclk) disable iff (!presetn)
		(feat_en != 4'h0) |=> slow_rc_en)
		else $error("Slow RC oscillator off while a timer feature needs it.");

	AST_LF_SRC: assert property (@(posedge pclk) disable iff (!presetn)
		(is_internal(mode) && freq_sel == `OCS_FREQ_31K && lf_src_sel)
		|=> clk_src_sel == ocs_pkg::OCS_SRC_FAST_DIV)
		else $error("Low-frequency source select ignored.");

	AST_SETTLE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_hit && paddr == `OCS_OFF_TUNE) |=> tune_settling [*2])
		else $error("Tuning write did not open the settle window.");

endmodule : ocs_top
`default_nettype wire

// File: verif/ocs_ext_source.sv
// Far-side model: external clock source or crystal network on the oscillator pins.
`timescale 1ns/1ps
`default_nettype none
module ocs_ext_source (
	input wire logic pclk,
	input wire logic run,
	input wire ocs_pkg::ocs_pin_s in_drv,
	input wire ocs_pkg::ocs_pin_s out_drv,
	output logic in_lvl,
	output logic out_lvl
);
	logic [2:0] cnt = 3'h0;

	always_ff @(posedge pclk) begin
		cnt <= cnt + 3'h1;
	end

	// An undriven line churns every cycle (the input line every four cycles while run), so a stale level can never pass for a driven one.
	assign in_lvl = in_drv.oe ? in_drv.o : (run ? cnt[2] : cnt[0]);
	assign out_lvl = out_drv.oe ? out_drv.o : cnt[0];
endmodule : ocs_ext_source
`default_nettype wire

// File: verif/test_ocs_top.sv
// Self-checking testbench of the oscillator select block.
`timescale 1ns/1ps
`default_nettype none
`include "ocs_regs.svh"
module test_ocs_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] osc_mode_cfg = 4'h0;
	logic fast_osc_tick = 1'b0;
	logic tick_on = 1'b0;
	logic in_lvl;
	logic out_lvl;
	ocs_pkg::ocs_pin_s in_drv;
	ocs_pkg::ocs_pin_s out_drv;
	ocs_pkg::ocs_pin_s pa_drv = '{o: 1'b1, oe: 1'b1};
	ocs_pkg::ocs_src_e clk_src_sel;
	logic [2:0] postscale_sel;
	logic xtal_mult_en, fast_internal_osc_mult_run, fast_osc_en, slow_rc_en, startup_delay_en;
	logic [4:0] tune_trim;
	logic tune_settling, lf_clk, pa6_in, pa7_in;
	logic [31:0] d;
	logic e;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;

	ocs_top #(.TUNE_SETTLE_CYC(16)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_mode_cfg(osc_mode_cfg),
		.fast_osc_tick(fast_osc_tick), .osc_in_pin_i(in_lvl), .osc_out_pin_i(out_lvl),
		.osc_in_pin_drv(in_drv), .osc_out_pin_drv(out_drv), .port_a_bit6_drv(pa_drv),
		.port_a_bit7_drv(pa_drv), .port_a_bit6_in(pa6_in), .port_a_bit7_in(pa7_in),
		.clk_src_sel(clk_src_sel), .postscale_sel(postscale_sel), .xtal_mult_en(xtal_mult_en),
		.fast_internal_osc_mult_run(fast_internal_osc_mult_run), .fast_osc_en(fast_osc_en), .slow_rc_en(slow_rc_en),
		.startup_delay_en(startup_delay_en), .tune_trim(tune_trim),
		.tune_settling(tune_settling), .lf_clk(lf_clk));

	ocs_ext_source i_src (.pclk(pclk), .run(osc_mode_cfg inside {4'h2, 4'h4, 4'h5, 4'h6}),
		.in_drv(in_drv), .out_drv(out_drv), .in_lvl(in_lvl), .out_lvl(out_lvl));

	initial begin
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		fast_osc_tick <= tick_on;
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// The request is held until pready is sampled high; no fixed latency is assumed.
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic settle();
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	task automatic do_reset(input logic [3:0] m);
		@(posedge pclk);
		presetn <= 1'b0;
		osc_mode_cfg <= m;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		settle();
	endtask : do_reset

	initial begin
		for (int m = 0; m < 10; m++) begin
			do_reset(4'(m));
			xfer(`OCS_OFF_STAT, 1'b0, 32'h0);
			chk(32'(d[4:0]), 32'(m) | 32'h10);
			osc_mode_cfg <= ~4'(m);
			pa_drv <= '{o: m[0], oe: 1'b1};
			settle();
			xfer(`OCS_OFF_STAT, 1'b0, 32'h0);
			settle();
			chk(32'(d[3:0]), 32'(m));
			chk(32'(xtal_mult_en), 32'(m == 6));
			chk(32'(startup_delay_en), 32'(!(m inside {4, 5})));
			chk(32'(out_drv.oe), 32'(m inside {3, 4, 5, 7, 8, 9}));
			chk(32'(in_drv.oe), 32'(m inside {8, 9}));
			chk(32'(pa6_in), 32'(m inside {5, 7, 8} && m[0]));
			chk(32'(pa7_in), 32'(m inside {8, 9} && m[0]));
			if (m inside {5, 7, 8}) chk(32'(out_drv.o), 32'(m[0]));
			if (m inside {8, 9}) chk(32'(in_drv.o), 32'(m[0]));
			if (m inside {3, 4, 9}) begin
				n = 0;
				repeat (8) begin
					d[0] = out_lvl;
					@(negedge pclk);
					n += int'(d[0] != out_lvl);
				end
				chk(32'(n), 32'h4);
			end
		end
		$display("test mode_decode done");
		do_reset(4'h9);
		xfer(`OCS_OFF_CTRL, 1'b1, 32'h70);
		xfer(`OCS_OFF_TUNE, 1'b1, 32'h40);
		xfer(`OCS_OFF_TUNE, 1'b0, 32'h0);
		settle();
		chk(d, 32'h40);
		chk(32'(fast_internal_osc_mult_run), 32'h1);
		chk(32'(clk_src_sel), 32'(ocs_pkg::OCS_SRC_FAST_X4));
		xfer(`OCS_OFF_CTRL, 1'b1, 32'h50);
		settle();
		chk(32'(fast_internal_osc_mult_run), 32'h0);
		xfer(`OCS_OFF_CTRL, 1'b1, 32'h60);
		settle();
		chk(32'(fast_internal_osc_mult_run), 32'h1);
		do_reset(4'h3);
		xfer(`OCS_OFF_TUNE, 1'b1, 32'h40);
		xfer(`OCS_OFF_TUNE, 1'b0, 32'h0);
		chk(d, 32'h0);
		do_reset(4'h6);
		xfer(`OCS_OFF_TUNE, 1'b1, 32'hff);
		xfer(`OCS_OFF_TUNE, 1'b0, 32'h0);
		settle();
		chk(d, 32'h9f);
		chk(32'(xtal_mult_en), 32'h1);
		$display("test multiplier done");
		do_reset(4'h8);
		for (int f = 0; f < 8; f++) begin
			xfer(`OCS_OFF_CTRL, 1'b1, 32'(f) << 4);
			settle();
			chk(32'(fast_osc_en), 32'(f != 0));
			chk(32'(slow_rc_en), 32'(f == 0));
			chk(32'(postscale_sel), 32'(f));
			chk(32'(clk_src_sel), f == 7 ? 32'(ocs_pkg::OCS_SRC_FAST) : f == 0 ?
				32'(ocs_pkg::OCS_SRC_SLOW_RC) : 32'(ocs_pkg::OCS_SRC_POSTSCALED));
		end
		for (int b = 0; b < 4; b++) begin
			xfer(`OCS_OFF_FEAT, 1'b1, 32'h1 << b);
			settle();
			chk(32'(slow_rc_en), 32'h1);
		end
		xfer(`OCS_OFF_FEAT, 1'b1, 32'h0);
		settle();
		chk(32'(slow_rc_en), 32'h0);
		$display("test internal_select done");
		xfer(`OCS_OFF_CTRL, 1'b1, 32'h0);
		xfer(`OCS_OFF_TUNE, 1'b1, 32'h80);
		settle();
		chk(32'(clk_src_sel), 32'(ocs_pkg::OCS_SRC_FAST_DIV));
		chk(32'(fast_osc_en), 32'h1);
		tick_on = 1'b1;
		repeat (130) @(negedge pclk);
		chk(32'(lf_clk), 32'h1);
		repeat (130) @(negedge pclk);
		chk(32'(lf_clk), 32'h0);
		tick_on = 1'b0;
		$display("test low_freq done");
		xfer(`OCS_OFF_TUNE, 1'b1, 32'h0a);
		@(negedge pclk);
		chk(32'(tune_trim), 32'h0a);
		n = 0;
		while (tune_settling === 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		chk(32'(n), 32'h10);
		xfer(12'h010, 1'b0, 32'h0);
		chk({d[31:1], e}, 32'h1);
		$display("test tune_and_bus done");
		close_out();
	end
endmodule : test_ocs_top
`default_nettype wire
